// ==== design/pcmd_pkg.sv ====
// Function
// - Option-write opcode copies accumulator to option register
// - Option register holds real-time counter settings
// - Opcode low nibble 5..9 selects ports A..E
// - Selector picks control register and access kind
// - Port data registers unreachable through control move
// - Selector 1F reaches direction; 1 means input
// - Selector low nibble 8 exchanges port B comparator
// - Writing zero enables comparator; old value returned
// - Literal selector load writes low four/five bits
// - Accumulator-to-selector copies low bits, keeps accumulator
package pcmd_pkg;
	localparam int          DATA_W        = 8;
	localparam int          ADDR_W        = 8;
	localparam int          NUM_PORTS     = 5;
	// Register byte offsets
	localparam logic [7:0]  OFS_INSTR     = 8'h00;
	localparam logic [7:0]  OFS_ACC       = 8'h04;
	localparam logic [7:0]  OFS_SEL       = 8'h08;
	localparam logic [7:0]  OFS_OPTION    = 8'h0C;
	localparam logic [7:0]  OFS_CMP       = 8'h10;
	localparam logic [7:0]  OFS_PORT_BASE = 8'h20;
	// Opcodes
	localparam logic [11:0] OP_OPTION_WR  = 12'h002;
	localparam logic [7:0]  OP_PORT_HI    = 8'h00;
	localparam logic [3:0]  OP_PORT_FIRST = 4'h5;
	localparam logic [3:0]  OP_PORT_LAST  = 4'h9;
	localparam logic [3:0]  OP_PORT_B     = 4'h6;
	localparam logic [7:0]  OP_SEL_LIT_HI = 8'h05;
	localparam logic [11:0] OP_SEL_FROM_W = 12'h043;
	// Selector codes
	localparam logic [3:0]  SEL_CMP_NIB   = 4'h8;
	localparam logic [5:0]  SEL_WR_GROUP  = 6'h07;
	localparam logic [5:0]  SEL_RD_GROUP  = 6'h03;
	localparam logic [1:0]  FLD_SCHMITT   = 2'h0;
	localparam logic [1:0]  FLD_LEVEL     = 2'h1;
	localparam logic [1:0]  FLD_PULLUP    = 2'h2;
	localparam logic [1:0]  FLD_DIR       = 2'h3;
	// Reset values
	localparam logic [7:0]  RST_SEL       = 8'h1F;
	localparam logic [7:0]  RST_OPTION    = 8'hFF;
	localparam logic [7:0]  RST_CMP       = 8'hFF;
	localparam logic [7:0]  RST_PORT_REG  = 8'hFF;
	localparam logic [7:0]  RST_ACC       = 8'h00;
	// Comparator control field positions
	localparam int          CMP_EN_N_BIT  = 0;
	localparam int          CMP_OE_N_BIT  = 1;
endpackage

// ==== design/pcmd_port_bank.sv ====
`timescale 1ns/1ps
module pcmd_port_bank #(
	parameter int W = 8
) (
	input  wire logic         clk_in,
	input  wire logic         reset_in,
	input  wire logic         ce_in,
	input  wire logic         wr_en_in,
	input  wire logic [1:0]   field_in,
	input  wire logic [W-1:0] wdata_in,
	output logic      [W-1:0] dir_out,
	output logic      [W-1:0] pullup_out,
	output logic      [W-1:0] level_out,
	output logic      [W-1:0] schmitt_out
);
	// Elaboration-time refusal of widths that the core's read mux cannot serve
	if (W != pcmd_pkg::DATA_W) begin : g_bad_w
		$error("pcmd_port_bank: W must equal DATA_W");
	end

	wire wr_dir     = wr_en_in && (field_in == pcmd_pkg::FLD_DIR);
	wire wr_pullup  = wr_en_in && (field_in == pcmd_pkg::FLD_PULLUP);
	wire wr_level   = wr_en_in && (field_in == pcmd_pkg::FLD_LEVEL);
	wire wr_schmitt = wr_en_in && (field_in == pcmd_pkg::FLD_SCHMITT);

	// All pins come up as inputs with pull-ups off
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			dir_out     <= pcmd_pkg::RST_PORT_REG;
			pullup_out  <= pcmd_pkg::RST_PORT_REG;
			level_out   <= pcmd_pkg::RST_PORT_REG;
			schmitt_out <= pcmd_pkg::RST_PORT_REG;
		end else if (ce_in) begin
			if (wr_dir) dir_out <= wdata_in;
			if (wr_pullup) pullup_out <= wdata_in;
			if (wr_level) level_out <= wdata_in;
			if (wr_schmitt) schmitt_out <= wdata_in;
		end
	end
endmodule // pcmd_port_bank

// ==== design/pcmd_core.sv ====
`timescale 1ns/1ps
module pcmd_core #(
	parameter int LIT_W = 5
) (
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic        ce_in,
	input  wire logic        hsel_in,
	input  wire logic [7:0]  haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic        hready_in,
	input  wire logic [31:0] hwdata_in,
	output logic      [31:0] hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out,
	output logic      [7:0]  option_out,
	output logic      [7:0]  comparator_ctrl_out,
	output logic             comparator_on_out,
	output logic             comparator_pin_drive_out,
	output logic      [39:0] port_dir_out,
	output logic      [39:0] port_pullup_out,
	output logic      [39:0] port_level_out,
	output logic      [39:0] port_schmitt_out
);
	if (LIT_W != 4 && LIT_W != 5) begin : g_bad_lit_w
		$error("pcmd_core: LIT_W must be 4 or 5");
	end

	logic [7:0]  acc;
	logic [7:0]  sel;
	logic [7:0]  option_reg;
	logic [7:0]  cmp;
	logic [11:0] last_op;
	logic        dp_wr;
	logic [7:0]  dp_addr;
	logic [7:0]  next_acc;
	logic [7:0]  next_sel;
	logic [7:0]  next_option;
	logic [7:0]  next_cmp;
	logic [31:0] next_rdata;

	// Bus address phase
	wire        addr_ok  = hsel_in && hready_in && htrans_in[1];
	wire        wr_instr = dp_wr && (dp_addr == pcmd_pkg::OFS_INSTR);
	wire        wr_acc   = dp_wr && (dp_addr == pcmd_pkg::OFS_ACC);
	wire        wr_sel   = dp_wr && (dp_addr == pcmd_pkg::OFS_SEL);
	wire [11:0] op       = hwdata_in[11:0];

	// Instruction decode
	wire        is_opt   = wr_instr && (op == pcmd_pkg::OP_OPTION_WR);
	// Only control registers are reachable; data registers live elsewhere
	wire        is_port  = wr_instr && (op[11:4] == pcmd_pkg::OP_PORT_HI)
		&& (op[3:0] >= pcmd_pkg::OP_PORT_FIRST)
		&& (op[3:0] <= pcmd_pkg::OP_PORT_LAST);
	wire        is_mlit  = wr_instr && (op[11:4] == pcmd_pkg::OP_SEL_LIT_HI);
	wire        is_mw    = wr_instr && (op == pcmd_pkg::OP_SEL_FROM_W);
	wire [3:0]  port_off = op[3:0] - pcmd_pkg::OP_PORT_FIRST;
	wire [2:0]  port_idx = port_off[2:0];

	// Selector decides target and access kind
	wire        cmp_hit  = is_port && (op[3:0] == pcmd_pkg::OP_PORT_B)
		&& (sel[3:0] == pcmd_pkg::SEL_CMP_NIB);
	wire        fld_wr   = is_port && (sel[7:2] == pcmd_pkg::SEL_WR_GROUP);
	wire        fld_rd   = is_port && (sel[7:2] == pcmd_pkg::SEL_RD_GROUP);
	wire [1:0]  field    = sel[1:0];

	wire [7:0]  bank_dir     [0:4];
	wire [7:0]  bank_pullup  [0:4];
	wire [7:0]  bank_level   [0:4];
	wire [7:0]  bank_schmitt [0:4];
	wire [7:0]  fld_val;

	genvar g;
	generate
		for (g = 0; g < pcmd_pkg::NUM_PORTS; g++) begin : g_port
			pcmd_port_bank #(
				.W (pcmd_pkg::DATA_W)
			) u_bank (
				.clk_in      (clk_in),
				.reset_in    (reset_in),
				.ce_in       (ce_in),
				.wr_en_in    (fld_wr && (port_idx == 3'(g))),
				.field_in    (field),
				.wdata_in    (acc),
				.dir_out     (bank_dir[g]),
				.pullup_out  (bank_pullup[g]),
				.level_out   (bank_level[g]),
				.schmitt_out (bank_schmitt[g])
			);
			assign port_dir_out[g*8 +: 8]     = bank_dir[g];
			assign port_pullup_out[g*8 +: 8]  = bank_pullup[g];
			assign port_level_out[g*8 +: 8]   = bank_level[g];
			assign port_schmitt_out[g*8 +: 8] = bank_schmitt[g];
		end
	endgenerate

	assign fld_val = (field == pcmd_pkg::FLD_DIR)    ? bank_dir[port_idx] :
	                 (field == pcmd_pkg::FLD_PULLUP) ? bank_pullup[port_idx] :
	                 (field == pcmd_pkg::FLD_LEVEL)  ? bank_level[port_idx] :
	                                                   bank_schmitt[port_idx];

	// Next-state: one instruction per cycle, no flags anywhere in this block
	always_comb begin
		next_acc    = acc;
		next_sel    = sel;
		next_option = option_reg;
		next_cmp    = cmp;
		if (wr_acc) next_acc = hwdata_in[7:0];
		if (wr_sel) next_sel = hwdata_in[7:0];
		if (is_opt) next_option = acc;
		if (cmp_hit) begin
			next_cmp = acc;
			next_acc = cmp;
		end else if (fld_rd) begin
			next_acc = fld_val;
		end
		// Anything else, including unassigned selector codes, falls through
		if (is_mlit) next_sel[LIT_W-1:0] = op[LIT_W-1:0];
		if (is_mw) next_sel[LIT_W-1:0] = acc[LIT_W-1:0];
	end

	// Read mux forwards next accumulator, selector, option and comparator values so a read right after an instruction sees them
	wire [7:0] rd_off = haddr_in - pcmd_pkg::OFS_PORT_BASE;
	wire [2:0] rd_idx = rd_off[4:2];
	wire       rd_prt = (haddr_in >= pcmd_pkg::OFS_PORT_BASE) && (rd_off[7:2] < 6'h05)
		&& (haddr_in[1:0] == 2'h0);

	always_comb begin
		next_rdata = 32'h0000_0000;
		case (haddr_in)
			pcmd_pkg::OFS_INSTR:  next_rdata = {20'h0_0000, last_op};
			pcmd_pkg::OFS_ACC:    next_rdata = {24'h00_0000, next_acc};
			pcmd_pkg::OFS_SEL:    next_rdata = {24'h00_0000, next_sel};
			pcmd_pkg::OFS_OPTION: next_rdata = {24'h00_0000, next_option};
			pcmd_pkg::OFS_CMP:    next_rdata = {24'h00_0000, next_cmp};
			default: begin
				if (rd_prt) next_rdata = {bank_schmitt[rd_idx], bank_level[rd_idx],
					bank_pullup[rd_idx], bank_dir[rd_idx]};
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			dp_wr   <= 1'b0;
			dp_addr <= 8'h00;
			hrdata_out <= 32'h0000_0000;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end else if (ce_in) begin
			dp_wr   <= addr_ok && hwrite_in;
			dp_addr <= haddr_in;
			hrdata_out <= (addr_ok && !hwrite_in) ? next_rdata : 32'h0000_0000;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			acc <= pcmd_pkg::RST_ACC;
			sel <= pcmd_pkg::RST_SEL;
			option_reg <= pcmd_pkg::RST_OPTION;
			cmp <= pcmd_pkg::RST_CMP;
			last_op <= 12'h000;
			comparator_on_out <= 1'b0;
			comparator_pin_drive_out <= 1'b0;
		end else if (ce_in) begin
			acc <= next_acc;
			sel <= next_sel;
			option_reg <= next_option;
			cmp <= next_cmp;
			if (wr_instr) last_op <= op;
			comparator_on_out <= !next_cmp[pcmd_pkg::CMP_EN_N_BIT];
			comparator_pin_drive_out <= !next_cmp[pcmd_pkg::CMP_OE_N_BIT];
		end
	end

	assign option_out          = option_reg;
	assign comparator_ctrl_out = cmp;

	property p_opt_copy;
		@(posedge clk_in) disable iff (reset_in)
		(is_opt && ce_in) |=> (option_out == $past(acc)) && (acc == $past(acc));
	endproperty
	a_opt_copy: assert property (p_opt_copy) else $error("option copy wrong");

	property p_opt_hold;
		@(posedge clk_in) disable iff (reset_in)
		(!is_opt && ce_in) |=> $stable(option_out);
	endproperty
	a_opt_hold: assert property (p_opt_hold) else $error("option changed");

	property p_dir_b;
		@(posedge clk_in) disable iff (reset_in)
		(fld_wr && ce_in && port_idx == 3'h1 && field == pcmd_pkg::FLD_DIR)
			|=> port_dir_out[15:8] == $past(acc);
	endproperty
	a_dir_b: assert property (p_dir_b) else $error("port B direction not written");

	property p_cmp_swap;
		@(posedge clk_in) disable iff (reset_in)
		(cmp_hit && ce_in) |=> (comparator_ctrl_out == $past(acc)) && (acc == $past(cmp));
	endproperty
	a_cmp_swap: assert property (p_cmp_swap) else $error("comparator exchange wrong");

	property p_cmp_on;
		@(posedge clk_in) disable iff (reset_in)
		(cmp_hit && ce_in && acc == 8'h00) |=> comparator_on_out && comparator_pin_drive_out;
	endproperty
	a_cmp_on: assert property (p_cmp_on) else $error("comparator not enabled");

	property p_sel_lit;
		@(posedge clk_in) disable iff (reset_in)
		(is_mlit && ce_in) |=> (sel[3:0] == $past(op[3:0])) && $stable(acc);
	endproperty
	a_sel_lit: assert property (p_sel_lit) else $error("selector literal load wrong");

	property p_sel_w;
		@(posedge clk_in) disable iff (reset_in)
		(is_mw && ce_in) |=> (sel[3:0] == $past(acc[3:0])) && $stable(acc);
	endproperty
	a_sel_w: assert property (p_sel_w) else $error("selector from accumulator wrong");

	property p_idle_op;
		@(posedge clk_in) disable iff (reset_in)
		(wr_instr && ce_in && !cmp_hit && !fld_rd) |=> $stable(acc);
	endproperty
	a_idle_op: assert property (p_idle_op) else $error("accumulator disturbed");

	property p_port_rd;
		@(posedge clk_in) disable iff (reset_in)
		(fld_rd && ce_in) |=> acc == $past(fld_val);
	endproperty
	a_port_rd: assert property (p_port_rd) else $error("control read wrong");

	property p_port_range;
		@(posedge clk_in) disable iff (reset_in)
		(wr_instr && op[11:4] == 8'h00 && op[3:0] < 4'h5 && ce_in) |=> $stable(port_dir_out);
	endproperty
	a_port_range: assert property (p_port_range) else $error("bad port selected");
endmodule // pcmd_core

// ==== sim/tb.sv ====
`timescale 1ns/1ps
module tb;
	logic        clk_in    = 1'b0;
	logic        reset_in  = 1'b1;
	logic        hsel_in   = 1'b0;
	logic [7:0]  haddr_in  = 8'h00;
	logic [1:0]  htrans_in = 2'h0;
	logic        hwrite_in = 1'b0;
	logic [31:0] hwdata_in = 32'h0;
	logic [31:0] hrdata_out;
	logic        hreadyout_out;
	logic        hresp_out;
	logic        cmp_on;
	logic        cmp_pin;
	logic [7:0]  option_out;
	logic [7:0]  cmp_ctrl;
	logic [39:0] dir_q;
	logic [39:0] pullup_q;
	logic [39:0] level_q;
	logic [39:0] schmitt_q;
	logic [31:0] rd;
	int          n_mismatch      = 0;
	int          samples_checked = 0;

	always #25 clk_in = ~clk_in;

	pcmd_core #(.LIT_W(5)) DUT (
		.clk_in(clk_in), .reset_in(reset_in), .ce_in(1'b1), .hsel_in(hsel_in),
		.haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
		.hsize_in(3'h2), .hready_in(hreadyout_out), .hwdata_in(hwdata_in),
		.hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
		.option_out(option_out), .comparator_ctrl_out(cmp_ctrl),
		.comparator_on_out(cmp_on), .comparator_pin_drive_out(cmp_pin),
		.port_dir_out(dir_q), .port_pullup_out(pullup_q),
		.port_level_out(level_q), .port_schmitt_out(schmitt_q)
	);

	task automatic summarize;
		$display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// Address phase held until hready is seen, then data phase likewise
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_in);
		hsel_in   <= 1'b1;
		haddr_in  <= a;
		hwrite_in <= w;
		htrans_in <= 2'h2;
		do @(posedge clk_in); while (hreadyout_out !== 1'b1);
		htrans_in <= 2'h0;
		hwdata_in <= d;
		do @(posedge clk_in); while (hreadyout_out !== 1'b1);
		rd = hrdata_out;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 32'h0);
		check({8'h00, rd}, {8'h00, exp});
	endtask

	task automatic ex(input logic [11:0] op);
		bus(8'h00, 1'b1, {20'h0, op});
	endtask

	task automatic acc(input logic [7:0] v);
		bus(8'h04, 1'b1, {24'h0, v});
	endtask

	initial begin
		repeat (5000) @(posedge clk_in);
		n_mismatch++;
		summarize();
	end

	initial begin
		repeat (2) @(posedge clk_in);
		reset_in <= 1'b0;
		rdchk(8'h08, 32'h1F);
		rdchk(8'h04, 32'h00);
		rdchk(8'h0C, 32'hFF);
		rdchk(8'h10, 32'hFF);
		rdchk(8'h20, 32'hFFFFFFFF);
		rdchk(8'h14, 32'h0);
		check({39'h0, hresp_out}, 40'h0);
		check({39'h0, hreadyout_out}, 40'h1);
		acc(8'h3F);
		ex(12'h002);
		rdchk(8'h0C, 32'h3F);
		rdchk(8'h04, 32'h3F);
		check({32'h0, option_out}, 40'h3F);
		// Selector still holds the direction code from reset
		for (int i = 0; i < 5; i++) begin
			acc(8'h30 + 8'(i));
			ex(12'h005 + 12'(i));
		end
		rdchk(8'h24, 32'hFFFFFF31);
		check(dir_q, 40'h3433323130);
		// Selector codes for schmitt, level, pullup, direction writes on port C
		for (int c = 0; c < 4; c++) begin
			acc(8'h1C + 8'(c));
			ex(12'h043);
			rdchk(8'h04, 32'h1C + 32'(c));
			rdchk(8'h08, 32'h1C + 32'(c));
			acc(8'h50 + 8'(c));
			ex(12'h007);
		end
		rdchk(8'h28, 32'h50515253);
		check({schmitt_q[23:16], level_q[23:16], pullup_q[23:16]}, 40'h505152);
		// Read codes pull each port C field back into the accumulator
		for (int c = 0; c < 4; c++) begin
			acc(8'h0C + 8'(c));
			ex(12'h043);
			ex(12'h007);
			rdchk(8'h04, 32'h50 + 32'(c));
		end
		acc(8'h0B);
		ex(12'h043);
		acc(8'h77);
		ex(12'h007);
		ex(12'h00A);
		ex(12'h004);
		rdchk(8'h04, 32'h77);
		check(dir_q, 40'h3433533130);
		ex(12'h058);
		// Five-bit load: opcode bit 4 is always set, so the selector becomes 18
		rdchk(8'h08, 32'h18);
		acc(8'h00);
		ex(12'h006);
		rdchk(8'h04, 32'hFF);
		rdchk(8'h10, 32'h00);
		check({38'h0, cmp_on, cmp_pin}, 40'h3);
		// Upper selector bits set: exchange must still be chosen
		bus(8'h08, 1'b1, 32'hF8);
		acc(8'h5A);
		ex(12'h006);
		rdchk(8'h04, 32'h00);
		check({30'h0, cmp_ctrl, cmp_on, cmp_pin}, 40'h16A);
		ex(12'h005);
		rdchk(8'h04, 32'h00);
		rdchk(8'h10, 32'h5A);
		check(dir_q, 40'h3433533130);
		summarize();
	end
endmodule // tb
